// file: logic/lbr_params.svh
`ifndef LBR_PARAMS_SVH
`define LBR_PARAMS_SVH

// Register that is only answered by the address poll command
`define LBR_ADDRESS_REG    8'h01
// Packet error code, CRC-8 with x^8 + x^2 + x + 1
`define LBR_CRC_POLY       8'h07
`define LBR_CRC_INIT       8'h00
// Data check byte layout
`define LBR_CHK_ALARM_BIT  7
`define LBR_CHK_ERR_BIT    0
`define LBR_CHK_RSVD       6'h00
// Bit slot of the acknowledge within a nine-bit byte frame
`define LBR_ACK_SLOT       4'h8
`define LBR_LAST_DATA_SLOT 4'h7
// Relay buffer shape
`define LBR_FIFO_WIDTH     8
`define LBR_FIFO_DEPTH     16

`endif

// file: logic/lbr_pkg.sv
package lbr_pkg;

    // Lower port transaction phases
    typedef enum logic [2:0] {
        lbr_st_idle   = 3'h0,
        lbr_st_addr_w = 3'h1,
        lbr_st_cmd    = 3'h2,
        lbr_st_wait_rs = 3'h3,
        lbr_st_addr_r = 3'h4,
        lbr_st_tx     = 3'h5,
        lbr_st_done   = 3'h6
    } lbr_state_t;

endpackage

// file: logic/lbr_fifo_if.sv
`timescale 1ns/100ps
// Byte path between the upper port receiver and the lower port sender
interface lbr_fifo_if #(parameter int W = 8);
    logic [W-1:0] wr_data;
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] rd_data;
    logic         rd_valid;
    logic         rd_ready;

    modport user (output wr_data, output wr_valid, input wr_ready,
                  input rd_data, input rd_valid, output rd_ready);
    modport fifo (input wr_data, input wr_valid, output wr_ready,
                  output rd_data, output rd_valid, input rd_ready);
endinterface

// file: logic/lbr_fifo.sv
`timescale 1ns/100ps
module lbr_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk,    // System clock
    input wire logic rst_n,  // Asynchronous reset, active low
    lbr_fifo_if.fifo f       // Fill and drain sides
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic [W-1:0]  dout_r;
    logic          dv_r;

    ////////////////////////////////////////////////////////////////////////
    // Handshake decode; the output stage refills whenever it empties
    wire push = f.wr_valid && f.wr_ready;
    wire load = (cnt_r != '0) && (!dv_r || f.rd_ready);
    assign f.wr_ready = (cnt_r != (AW+1)'(D));
    assign f.rd_valid = dv_r;
    assign f.rd_data  = dout_r;
    assign cnt_nxt    = cnt_r + (AW+1)'(push) - (AW+1)'(load);

    // Storage has no reset: contents are never read before written
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= f.wr_data;
        end
    end

    // Pointers, count and registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r   <= '0;
            rp_r   <= '0;
            cnt_r  <= '0;
            dout_r <= '0;
            dv_r   <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            if (push) begin
                wp_r <= wp_r + 1'b1;  // Depth is a power of two, wraps
            end
            if (load) begin
                rp_r   <= rp_r + 1'b1;
                dout_r <= mem[rp_r];
                dv_r   <= 1'b1;
            end else if (f.rd_ready) begin
                dv_r <= 1'b0;
            end
        end
    end
endmodule

// file: logic/lbr_core.sv
// Functional notes
// - Registers are returned only by broadcast read; address register is refused here.
// - After the command, send own 16-bit register value, low byte first.
// - Forward the broadcast read command up the ladder to the next device.
// - Buffer upstream bytes; relay them only after own bytes and their acknowledge.
// - Last device appends data check byte then error code after its data.
// - Error code byte is CRC-8; host checks with the same CRC-8.
// - CRC covers both address bytes, command, every sent data byte, check byte.
// - Last device CRC covers command bytes, its two data bytes, check byte.
// - Last device sends alarm from own state and chain error flag zero.
// - Others OR received check byte with own alarm and upper CRC validity.
// - Others send merged check byte right after the last relayed data byte.
// - Bad upper CRC sets chain error flag and fault status before check byte.
// - Others recompute CRC over command bytes, all sent data, updated check byte.
// - Each link carries only own and higher data, then check and CRC.
// - First device sends all data, check byte, then its own CRC to host.
// - A bad CRC never aborts the transfer; only flags report it.
// - With fault alarm enabled, fault status also drives the alarm bus.
// - Check byte holds alarm in bit 7, error in bit 0, zeros between.
// - Last device address comes from the last node field.
// - CRC-8 generator polynomial is x^8 + x^2 + x + 1.
`timescale 1ns/100ps
`include "lbr_params.svh"
module lbr_core #(
    parameter logic [6:0] BCAST_ADDR = 7'h30  // Broadcast bus address
) (
    input  wire logic        clk,                     // System clock, 100 MHz
    input  wire logic        rst_n,                   // Asynchronous reset, active low
    input  wire logic        scl_l_i,                 // Lower port clock level
    input  wire logic        sda_l_i,                 // Lower port data level
    output wire logic        sda_l_o,                 // Lower port data drive value
    output logic             sda_l_oe,                // Lower port data pull low
    output wire logic        scl_u_o,                 // Upper port clock drive value
    output logic             scl_u_oe,                // Upper port clock pull low
    input  wire logic        sda_u_i,                 // Upper port data level
    output wire logic        sda_u_o,                 // Upper port data drive value
    output logic             sda_u_oe,                // Upper port data pull low
    input  wire logic [4:0]  own_addr,                // Assigned device address
    input  wire logic [4:0]  last_node_field,         // Address of the last device
    input  wire logic        alarm_in,                // Own alarm condition
    input  wire logic        crc_fault_alarm_enable,  // Fault status drives alarm bus
    input  wire logic        crc_fault_clear,         // Clear fault status
    output wire logic [7:0]  reg_rd_addr,             // Register selected by command
    input  wire logic [15:0] reg_rd_data,             // Register value to return
    output wire logic        crc_fault_status,        // Sticky upper CRC fault
    output logic             chain_alarm_out,         // Drive onto the alarm bus
    output logic             relay_overflow           // Relay buffer refused a byte
);
    ////////////////////////////////////////////////////////////////////////
    // CRC-8 update over one byte, MSB first
    function automatic logic [7:0] lbr_crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ `LBR_CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    logic [1:0]          scl_sync_r;
    logic [1:0]          sda_sync_r;
    logic [1:0]          sdu_sync_r;
    logic                scl_d_r;
    logic                sda_d_r;
    lbr_pkg::lbr_state_t state_r;
    lbr_pkg::lbr_state_t state_nxt;
    logic [3:0]          bit_r;
    logic [7:0]          shift_r;
    logic [7:0]          ushift_r;
    logic [6:0]          k_r;
    logic [7:0]          cmd_r;
    logic [7:0]          crc_cmd_r;
    logic [7:0]          crc_tx_r;
    logic [7:0]          crc_up_r;
    logic [7:0]          tx_byte_r;
    logic [7:0]          up_chk_r;
    logic                pec_bad_r;
    logic                fault_r;
    logic                lower_oe_nxt;
    logic                upper_oe_nxt;

    lbr_fifo_if #(.W(`LBR_FIFO_WIDTH)) relay_if ();

    lbr_fifo #(
        .W (`LBR_FIFO_WIDTH),
        .D (`LBR_FIFO_DEPTH)
    ) u_relay (
        .clk   (clk),
        .rst_n (rst_n),
        .f     (relay_if.fifo)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is ever looked at
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            sdu_sync_r <= 2'h3;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_l_i};
            sda_sync_r <= {sda_sync_r[0], sda_l_i};
            sdu_sync_r <= {sdu_sync_r[0], sda_u_i};
            scl_d_r    <= scl_sync_r[1];
            sda_d_r    <= sda_sync_r[1];
        end
    end

    // Edge, start and stop detection on the lower port
    wire scl_s    = scl_sync_r[1];
    wire sda_s    = sda_sync_r[1];
    wire sdu_s    = sdu_sync_r[1];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Byte framing and chain position
    wire [7:0] rx_byte  = {shift_r[6:0], sda_s};
    wire [7:0] up_byte  = {ushift_r[6:0], sdu_s};
    wire       rx_done  = scl_rise && (bit_r == `LBR_LAST_DATA_SLOT);
    wire       ack_end  = scl_rise && (bit_r == `LBR_ACK_SLOT);
    wire       in_tx    = (state_r == lbr_pkg::lbr_st_tx);
    wire       in_rx    = (state_r == lbr_pkg::lbr_st_addr_w) || (state_r == lbr_pkg::lbr_st_cmd) ||
                          (state_r == lbr_pkg::lbr_st_addr_r);
    wire       is_last  = (own_addr == last_node_field);
    wire [4:0] n_above  = last_node_field - own_addr;
    wire [6:0] n2       = {1'b0, n_above, 1'b0};  // Relayed data bytes; zero when last
    wire       tx_bit   = tx_byte_r[3'(4'h7 - bit_r)];

    ////////////////////////////////////////////////////////////////////////
    // Transaction sequencer
    always_comb begin
        state_nxt = state_r;
        if (stop_ev) begin
            state_nxt = lbr_pkg::lbr_st_idle;
        end else if (start_ev) begin
            state_nxt = (state_r == lbr_pkg::lbr_st_wait_rs) ? lbr_pkg::lbr_st_addr_r
                                                             : lbr_pkg::lbr_st_addr_w;
        end else begin
            case (state_r)
                lbr_pkg::lbr_st_addr_w: begin
                    if (rx_done && rx_byte != {BCAST_ADDR, 1'b0}) begin
                        state_nxt = lbr_pkg::lbr_st_idle;
                    end else if (ack_end) begin
                        state_nxt = lbr_pkg::lbr_st_cmd;
                    end
                end
                lbr_pkg::lbr_st_cmd: begin
                    if (ack_end) begin
                        state_nxt = lbr_pkg::lbr_st_wait_rs;
                    end
                end
                lbr_pkg::lbr_st_addr_r: begin
                    if (rx_done && (rx_byte != {BCAST_ADDR, 1'b1} || cmd_r == `LBR_ADDRESS_REG)) begin
                        state_nxt = lbr_pkg::lbr_st_idle;
                    end else if (ack_end) begin
                        state_nxt = lbr_pkg::lbr_st_tx;
                    end
                end
                lbr_pkg::lbr_st_tx: begin
                    if (ack_end && k_r == n2 + 7'h03) begin
                        state_nxt = lbr_pkg::lbr_st_done;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Outgoing byte selection: own pair, relayed bytes, check byte, code
    wire       load_ev   = ack_end && (state_nxt == lbr_pkg::lbr_st_tx);
    wire [6:0] k_nxt     = (state_r == lbr_pkg::lbr_st_addr_r) ? 7'h00 : k_r + 7'h01;
    wire       sel_relay = (k_nxt > 7'h01) && (k_nxt < n2 + 7'h02);
    wire       sel_chk   = (k_nxt == n2 + 7'h02);
    wire       sel_pec   = (k_nxt == n2 + 7'h03);
    wire       chk_alarm = alarm_in | (~is_last & up_chk_r[`LBR_CHK_ALARM_BIT]);
    wire       chk_err   = ~is_last & (up_chk_r[`LBR_CHK_ERR_BIT] | pec_bad_r);
    wire [7:0] chk_byte  = {chk_alarm, `LBR_CHK_RSVD, chk_err};
    wire [7:0] relay_byte = relay_if.rd_valid ? relay_if.rd_data : 8'hFF;  // Idle bus on underrun
    wire [7:0] next_byte = (k_nxt == 7'h00) ? reg_rd_data[7:0] :
                           (k_nxt == 7'h01) ? reg_rd_data[15:8] :
                           sel_relay        ? relay_byte :
                           sel_chk          ? chk_byte : crc_tx_r;
    wire [7:0] crc_base  = (state_r == lbr_pkg::lbr_st_addr_r) ? crc_cmd_r : crc_tx_r;

    // Upper port reception runs in the same bit slots as our own sending
    wire       up_rx     = in_tx && !is_last && scl_rise && (bit_r < `LBR_ACK_SLOT);
    wire       up_done   = in_tx && !is_last && rx_done;
    wire       up_data   = up_done && (k_r < n2);
    wire       up_chk    = up_done && (k_r == n2);
    wire       pec_bad_ev = up_done && (k_r == n2 + 7'h01) && (up_byte != crc_up_r);

    assign relay_if.wr_data  = up_byte;
    assign relay_if.wr_valid = up_data;
    assign relay_if.rd_ready = load_ev && sel_relay;
    assign reg_rd_addr       = cmd_r;
    assign crc_fault_status  = fault_r;
    assign sda_l_o           = 1'b0;
    assign sda_u_o           = 1'b0;
    assign scl_u_o           = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Lower port drive: acknowledge received bytes, shift out on falling clock
    always_comb begin
        lower_oe_nxt = sda_l_oe;
        if (start_ev || stop_ev || state_r == lbr_pkg::lbr_st_idle) begin
            lower_oe_nxt = 1'b0;
        end else if (scl_fall) begin
            if (in_rx && bit_r == `LBR_ACK_SLOT) begin
                lower_oe_nxt = 1'b1;
            end else if (in_tx && bit_r < `LBR_ACK_SLOT) begin
                lower_oe_nxt = ~tx_bit;
            end else begin
                lower_oe_nxt = 1'b0;  // Host owns the acknowledge slot
            end
        end
    end

    // Upper port drive: mirror the command upward, acknowledge relayed bytes
    always_comb begin
        upper_oe_nxt = sda_u_oe;
        if (!in_tx) begin
            upper_oe_nxt = ~sda_s;
        end else if (scl_fall) begin
            upper_oe_nxt = !is_last && (bit_r == `LBR_ACK_SLOT) && (k_r < n2 + 7'h02);
        end
    end

    // Pin drive registers; clock is relayed so the upper stream keeps our bit slots
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_l_oe <= 1'b0;
            sda_u_oe <= 1'b0;
            scl_u_oe <= 1'b0;
        end else begin
            sda_l_oe <= lower_oe_nxt;
            sda_u_oe <= upper_oe_nxt;
            scl_u_oe <= ~scl_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, bit counter and shifters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= lbr_pkg::lbr_st_idle;
            bit_r    <= 4'h0;
            shift_r  <= 8'h00;
            ushift_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (start_ev) begin
                bit_r <= 4'h0;
            end else if (scl_rise && state_r != lbr_pkg::lbr_st_idle) begin
                bit_r <= (bit_r == `LBR_ACK_SLOT) ? 4'h0 : bit_r + 4'h1;
            end
            if (scl_rise && bit_r < `LBR_ACK_SLOT) begin
                shift_r <= rx_byte;
            end
            if (up_rx) begin
                ushift_r <= up_byte;
            end
        end
    end

    // Command capture and the CRC over the command-phase bytes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r     <= 8'h00;
            crc_cmd_r <= `LBR_CRC_INIT;
        end else begin
            if (start_ev && state_r != lbr_pkg::lbr_st_wait_rs) begin
                crc_cmd_r <= `LBR_CRC_INIT;
            end else if (rx_done && in_rx) begin
                crc_cmd_r <= lbr_crc8(crc_cmd_r, rx_byte);
            end
            if (rx_done && state_r == lbr_pkg::lbr_st_cmd) begin
                cmd_r <= rx_byte;
            end
        end
    end

    // Outgoing byte, slot index and the recomputed link CRC
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_r <= 8'hFF;
            k_r       <= 7'h00;
            crc_tx_r  <= `LBR_CRC_INIT;
        end else if (load_ev) begin
            tx_byte_r <= next_byte;
            k_r       <= k_nxt;
            if (!sel_pec) begin
                crc_tx_r <= lbr_crc8(crc_base, next_byte);
            end
        end
    end

    // Upper port check: expected CRC, received check byte, per-frame error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_up_r  <= `LBR_CRC_INIT;
            up_chk_r  <= 8'h00;
            pec_bad_r <= 1'b0;
        end else begin
            if (start_ev && state_r != lbr_pkg::lbr_st_wait_rs) begin
                up_chk_r  <= 8'h00;
                pec_bad_r <= 1'b0;
            end else if (pec_bad_ev) begin
                pec_bad_r <= 1'b1;
            end
            if (load_ev && state_r == lbr_pkg::lbr_st_addr_r) begin
                crc_up_r <= crc_cmd_r;
            end else if (up_data || up_chk) begin
                crc_up_r <= lbr_crc8(crc_up_r, up_byte);
            end
            if (up_chk) begin
                up_chk_r <= up_byte;
            end
        end
    end

    // Sticky status; a fault in the clearing cycle is kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r         <= 1'b0;
            chain_alarm_out <= 1'b0;
            relay_overflow  <= 1'b0;
        end else begin
            if (pec_bad_ev) begin
                fault_r <= 1'b1;
            end else if (crc_fault_clear) begin
                fault_r <= 1'b0;
            end
            chain_alarm_out <= alarm_in | (crc_fault_alarm_enable & fault_r);
            if (start_ev && state_r != lbr_pkg::lbr_st_wait_rs) begin
                relay_overflow <= 1'b0;
            end else if (up_data && !relay_if.wr_ready) begin
                relay_overflow <= 1'b1;  // Byte lost; upstream cannot be stalled
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above
    a_cmd_forward: assert property (@(posedge clk) disable iff (!rst_n)
        (!in_tx && !sda_s) |=> sda_u_oe) else $error("command not forwarded upward");
    a_own_low_first: assert property (@(posedge clk) disable iff (!rst_n)
        (load_ev && state_r == lbr_pkg::lbr_st_addr_r) |=> tx_byte_r == $past(reg_rd_data[7:0]))
        else $error("low byte not sent first");
    a_own_high_next: assert property (@(posedge clk) disable iff (!rst_n)
        (load_ev && k_nxt == 7'h01) |=> tx_byte_r == $past(reg_rd_data[15:8]))
        else $error("high byte not second");
    a_pec_appended: assert property (@(posedge clk) disable iff (!rst_n)
        (load_ev && sel_pec) |=> (tx_byte_r == $past(crc_tx_r)) && (crc_tx_r == $past(crc_tx_r)))
        else $error("wrong error code byte");
    a_last_no_err: assert property (@(posedge clk) disable iff (!rst_n)
        is_last |-> !chk_byte[`LBR_CHK_ERR_BIT]) else $error("last device flags chain error");
    a_err_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        pec_bad_ev |=> fault_r && chk_byte[`LBR_CHK_ERR_BIT]) else $error("bad code not flagged");
    a_no_abort: assert property (@(posedge clk) disable iff (!rst_n)
        (pec_bad_ev && !stop_ev) |=> in_tx) else $error("transfer aborted on bad code");
    a_alarm_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (crc_fault_alarm_enable && fault_r) |=> chain_alarm_out) else $error("fault alarm missing");
    a_relay_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (load_ev && k_nxt < 7'h02) |-> !relay_if.rd_ready) else $error("relay before own bytes");
    a_last_quiet_up: assert property (@(posedge clk) disable iff (!rst_n)
        (is_last && in_tx && scl_fall) |=> !sda_u_oe) else $error("last device drives upper port");
    a_tx_ack_free: assert property (@(posedge clk) disable iff (!rst_n)
        (in_tx && scl_fall && bit_r == `LBR_ACK_SLOT) |=> !sda_l_oe) else $error("ack slot not released");
endmodule

// file: dv/lbr_upper_model.sv
`timescale 1ns/100ps
// Last device above ours: answers a broadcast read with two data bytes, check byte and PEC
module lbr_upper_model (
    input  wire logic        scl,   // Relayed clock from the device below
    input  wire logic        sda,   // Resolved upper data line
    input  wire logic [31:0] tx,    // Low, high, check, PEC bytes, first byte on top
    output logic             pull   // High while pulling the data line low
);
    int s = 0;
    int n = 0;
    int p;
    initial pull = 1'b0;
    // Start restarts the slot count; only the read phase after the repeated start sends
    // Clock level is looked at 1 ns late: the device below moves data in the step its clock falls
    always @(negedge sda) begin
        #1;
        if (scl) begin
            s++;
            n = 0;
        end
    end
    always @(posedge sda) begin
        #1;
        if (scl)
            s = 0;
    end
    always @(posedge scl) n++;
    // Bits change on the falling clock, long before the next rise; ack slots are left free
    always @(negedge scl) begin
        p = (n - 9) / 9 * 8 + (n - 9) % 9;
        pull <= s == 2 && n >= 9 && n < 45 && (n - 9) % 9 != 8 && !tx[31 - p];
    end
endmodule

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
    logic        clk = 0, rst_n = 0, scl = 1, sda = 1, alarm = 0, en = 1, clr = 0, ak;
    logic [4:0]  own = 5'h05, last = 5'h05;
    logic [15:0] rdat = 16'hA55A;
    logic [31:0] up_tx = 32'hFFFFFFFF;
    logic [7:0]  got [6], e [6], c;
    wire         sda_l_oe, scl_u_oe, sda_u_oe, pull, fault, alm, ovf, lo, uo, co;
    wire  [7:0]  ra;
    wire         sdl = sda & !sda_l_oe;
    wire         scu = !scl_u_oe;
    wire         sdu = !(sda_u_oe | pull);
    int          n_mismatch = 0, checked = 0, cyc = 0;
    always #5 clk = !clk;
    lbr_core i_dut (.clk(clk), .rst_n(rst_n), .scl_l_i(scl), .sda_l_i(sdl), .sda_l_o(lo), .sda_l_oe(sda_l_oe),
        .scl_u_o(co), .scl_u_oe(scl_u_oe), .sda_u_i(sdu), .sda_u_o(uo), .sda_u_oe(sda_u_oe), .own_addr(own),
        .last_node_field(last), .alarm_in(alarm), .crc_fault_alarm_enable(en), .crc_fault_clear(clr),
        .reg_rd_addr(ra), .reg_rd_data(rdat), .crc_fault_status(fault), .chain_alarm_out(alm), .relay_overflow(ovf));
    lbr_upper_model i_up (.scl(scu), .sda(sdu), .tx(up_tx), .pull(pull));
    // Host side bit timing: 160 ns per bit, data moved 20 ns after the clock falls
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic bt(input logic b, output logic r);
        sda = b;
        wt(6);
        scl = 1;
        wt(8);
        r = sdl;
        scl = 0;
        wt(2);
    endtask
    task automatic start();
        sda = 1;
        wt(4);
        scl = 1;
        wt(4);
        sda = 0;
        wt(4);
        scl = 0;
        wt(2);
    endtask
    task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
        bt(a, k);
    endtask
    // Broadcast read: write address, command, repeated start, read address, nb bytes
    task automatic rd(input logic [7:0] cmd, input int nb);
        logic k;
        start();
        xb(8'h60, 1, c, k);
        xb(cmd, 1, c, k);
        start();
        xb(8'h61, 1, c, ak);
        for (int i = 0; i < nb; i++) xb(8'hFF, 0, got[i], k);
        sda = 0;
        wt(4);
        scl = 1;
        wt(4);
        sda = 1;
        wt(8);
    endtask
    function automatic logic [7:0] cr(input logic [7:0] x0, input logic [7:0] d);
        logic [7:0] x;
        x = x0 ^ d;
        repeat (8) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction
    // PEC over the three command bytes then e[0..nb-1]
    function automatic logic [7:0] pec(input logic [7:0] cmd, input int nb);
        logic [7:0] x;
        x = cr(cr(cr(8'h00, 8'h60), cmd), 8'h61);
        for (int i = 0; i < nb; i++) x = cr(x, e[i]);
        return x;
    endfunction
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1;
        wt(4);
        // Last device: own word, check byte from own alarm, then PEC
        alarm = 1;
        rd(8'h2C, 4);
        e = '{8'h5A, 8'hA5, 8'h80, 8'h00, 8'h00, 8'h00};
        e[3] = pec(8'h2C, 3);
        for (int i = 0; i < 4; i++) chk("last byte", got[i], e[i]);
        chk("command", ra, 8'h2C);
        $display("test last device done");
        // Address register is not readable this way: read address refused
        rd(8'h01, 0);
        chk("address nack", {7'h00, ak}, 8'h01);
        $display("test refused read done");
        // Relay from the device above, with a good and then a corrupted upper PEC
        own = 5'h04;
        alarm = 0;
        for (int b = 0; b < 2; b++) begin
            e = '{8'h11, 8'h22, 8'h80, 8'h00, 8'h00, 8'h00};
            up_tx = {8'h11, 8'h22, 8'h80, pec(8'h37, 3) ^ 8'(b)};
            e = '{8'h5A, 8'hA5, 8'h11, 8'h22, 8'h80 | 8'(b), 8'h00};
            e[5] = pec(8'h37, 5);
            rd(8'h37, 6);
            for (int i = 0; i < 6; i++) chk("relay byte", got[i], e[i]);
            chk("fault status", {7'h00, fault}, 8'(b));
            chk("alarm bus", {7'h00, alm}, 8'(b));
            chk("chain error flag", {7'h00, got[4][0]}, 8'(b));
            chk("overflow", {7'h00, ovf}, 8'h00);
            chk("drive values", {5'h00, lo, uo, co}, 8'h00);
            $display("test relay done");
        end
        // Fault still set here: with the enable off it must not reach the alarm bus
        en = 0;
        wt(2);
        chk("alarm gated", {7'h00, alm}, 8'h00);
        en = 1;
        clr = 1;
        wt(2);
        clr = 0;
        wt(2);
        chk("fault clear", {7'h00, fault}, 8'h00);
        wrap_up();
    end
endmodule
